/* verilog/csi_codec_init.sv */
// start-up sequencer that programs the stereo converter over serial control
// assumes converter_enable_n and mute_sel are static straps; lclk runs free
//
// Notes on behaviour
// - program converter after reset before audio use
// - every frame carries chip address 001000
// - three-bit pointer selects one of eight bytes
// - byte 1 ADC control written zero
// - byte 2 zero or 60 mute; 3,4 zero
// - byte 5 DSP mode written 0F
// - byte 7 master clock written zero
// - control reaches converter only via serial port
// - start only while enable bit reads zero
`default_nettype none
module csi_codec_init
  import csi_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic lclk,
  input wire logic lrst_b,
  input wire logic converter_enable_n,
  input wire logic mute_sel,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  output logic init_busy,
  output logic init_done
);
  // ============================================================
  // state
  typedef struct packed {
    csi_state_t state;
    logic [2:0] ptr;
    logic [23:0] frame;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic en_s1;
    logic en_s2;
    logic mute_s1;
    logic mute_s2;
    logic busy;
    logic done;
  } csi_seq_t;
  csi_seq_t st_r, st_nxt;
  csi_link_if lnk();

  function automatic logic [7:0] csi_value(input logic [2:0] p, input logic mute);
    logic [7:0] v;
    v = CSI_VAL_ADC;
    case (p)
      CSI_BYTE_DAC: v = mute ? CSI_VAL_DAC_MUTE : CSI_VAL_DAC;
      CSI_BYTE_ATT_L, CSI_BYTE_ATT_R: v = CSI_VAL_ATT;
      CSI_BYTE_DSP: v = CSI_VAL_DSP;
      CSI_BYTE_MCLK: v = CSI_VAL_MCLK;
      default: v = CSI_VAL_ADC;
    endcase
    return v;
  endfunction

  // ============================================================
  // sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack_s1 = lnk.ack_tgl;
    st_nxt.ack_s2 = st_r.ack_s1;
    st_nxt.en_s1 = converter_enable_n;
    st_nxt.en_s2 = st_r.en_s1;
    st_nxt.mute_s1 = mute_sel;
    st_nxt.mute_s2 = st_r.mute_s1;
    unique case (st_r.state)
      CSI_IDLE: begin
        if (!st_r.en_s2) begin
          st_nxt.state = CSI_LOAD;
          st_nxt.ptr = CSI_BYTE_ADC;
          st_nxt.busy = 1'b1;
        end
      end
      CSI_LOAD: begin
        // write frame: address, r/w low, pad, pointer, data
        st_nxt.frame = {CSI_CHIP_ADDR, 1'b0, 6'h00, st_r.ptr, csi_value(st_r.ptr, st_r.mute_s2)};
        st_nxt.req = ~st_r.req;
        st_nxt.state = CSI_WAIT;
      end
      CSI_WAIT: begin
        if (st_r.ack_s2 == st_r.req) begin
          st_nxt.state = CSI_NEXT;
        end
      end
      CSI_NEXT: begin
        if (st_r.ptr == CSI_BYTE_MCLK) begin
          st_nxt.state = CSI_DONE;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
        end else begin
          // status byte is read only, so it is stepped over
          st_nxt.ptr = (st_r.ptr == CSI_BYTE_DSP) ? CSI_BYTE_MCLK : st_r.ptr + 3'h1;
          st_nxt.state = CSI_LOAD;
        end
      end
      CSI_DONE: begin
        st_nxt.state = CSI_DONE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.state <= CSI_IDLE;
      st_r.en_s1 <= 1'b1;
      st_r.en_s2 <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.frame = st_r.frame;
  assign lnk.req_tgl = st_r.req;
  assign init_busy = st_r.busy;
  assign init_done = st_r.done;

  // ============================================================
  // serial engine on the link clock
  csi_spi_engine u_eng (
    .lclk(lclk),
    .lrst_b(lrst_b),
    .lnk(lnk),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .mosi(spi_mosi)
  );

  // ============================================================
  // checks
  property p_addr;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_WAIT |-> st_r.frame[23:18] == 6'h08;
  endproperty
  a_addr: assert property (p_addr) else $error("bad chip address");
  property p_no_status;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_WAIT |-> st_r.frame[10:8] != 3'h6 && st_r.frame[10:8] != 3'h0;
  endproperty
  a_no_status: assert property (p_no_status) else $error("status or unused byte written");
  property p_dsp;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_WAIT && st_r.frame[10:8] == 3'h5 |-> st_r.frame[7:0] == 8'h0F;
  endproperty
  a_dsp: assert property (p_dsp) else $error("dsp byte wrong");
  property p_dac;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_WAIT && st_r.frame[10:8] == 3'h2 |-> st_r.frame[7:0] == (st_r.mute_s2 ? 8'h60 : 8'h00);
  endproperty
  a_dac: assert property (p_dac) else $error("dac byte wrong");
  property p_zero;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_WAIT && st_r.frame[10:8] inside {3'h1, 3'h3, 3'h4, 3'h7} |-> st_r.frame[7:0] == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("zero byte wrong");
  property p_mclk_zero;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_WAIT && st_r.frame[10:8] == 3'h7 |-> st_r.frame[7:0] == 8'h00;
  endproperty
  a_mclk_zero: assert property (p_mclk_zero) else $error("master clock byte wrong");
  property p_enable;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_IDLE && st_r.en_s2 |=> st_r.state == CSI_IDLE;
  endproperty
  a_enable: assert property (p_enable) else $error("started while disabled");
  property p_order;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_NEXT && st_r.ptr != 3'h7 |=> st_r.state == CSI_LOAD && st_r.ptr > $past(st_r.ptr);
  endproperty
  a_order: assert property (p_order) else $error("pointer not ascending");
  property p_done;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_NEXT && st_r.ptr == 3'h7 |=> init_done && !init_busy;
  endproperty
  a_done: assert property (p_done) else $error("done not raised");

  // ============================================================
  // frame handshake and sequencing checks
  property p_frame_format;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_WAIT |-> st_r.frame[17:11] == 7'h00;
  endproperty
  a_frame_format: assert property (p_frame_format) else $error("write bit or pad not zero");
  property p_frame_hold;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_WAIT |=> $stable(st_r.frame);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame word moved during handshake");
  property p_start;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_IDLE && !st_r.en_s2 |=> st_r.state == CSI_LOAD && st_r.ptr == CSI_BYTE_ADC && init_busy;
  endproperty
  a_start: assert property (p_start) else $error("sequence did not start at adc byte");
  property p_req_toggle;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_LOAD |=> st_r.req != $past(st_r.req);
  endproperty
  a_req_toggle: assert property (p_req_toggle) else $error("frame request not raised");
  property p_wait_ack;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_WAIT && st_r.ack_s2 != st_r.req |=> st_r.state == CSI_WAIT;
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("moved on before frame acknowledged");
  property p_skip;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_NEXT && st_r.ptr == CSI_BYTE_DSP |=> st_r.ptr == CSI_BYTE_MCLK;
  endproperty
  a_skip: assert property (p_skip) else $error("status byte not skipped");
  property p_done_hold;
    @(posedge mclk) disable iff (!rst_b)
    init_done |=> init_done && !init_busy;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done not held");
  property p_idle_quiet;
    @(posedge mclk) disable iff (!rst_b)
    st_r.state == CSI_IDLE |-> !init_busy && !init_done;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("busy or done while idle");
endmodule
`default_nettype wire

/* include/csi_pkg.sv */
// constants and types for the converter start-up sequencer
// assumes a 100 MHz system clock and a slower link clock of its own
`default_nettype none
package csi_pkg;
  // ============================================================
  // converter addressing
  localparam logic [5:0] CSI_CHIP_ADDR = 6'h08;
  localparam int CSI_BYTE_COUNT = 8;
  localparam int CSI_PTR_W = 3;
  // ============================================================
  // byte pointers and values
  localparam logic [2:0] CSI_BYTE_ADC = 3'h1;
  localparam logic [2:0] CSI_BYTE_DAC = 3'h2;
  localparam logic [2:0] CSI_BYTE_ATT_L = 3'h3;
  localparam logic [2:0] CSI_BYTE_ATT_R = 3'h4;
  localparam logic [2:0] CSI_BYTE_DSP = 3'h5;
  localparam logic [2:0] CSI_BYTE_STATUS = 3'h6;
  localparam logic [2:0] CSI_BYTE_MCLK = 3'h7;
  localparam logic [7:0] CSI_VAL_ADC = 8'h00;
  localparam logic [7:0] CSI_VAL_DAC = 8'h00;
  localparam logic [7:0] CSI_VAL_DAC_MUTE = 8'h60;
  localparam logic [7:0] CSI_VAL_ATT = 8'h00;
  localparam logic [7:0] CSI_VAL_DSP = 8'h0F;
  localparam logic [7:0] CSI_VAL_MCLK = 8'h00;
  // ============================================================
  // frame layout: address(6) + r/w(1) + pad(6) + pointer(3) + data(8)
  localparam int CSI_FRAME_W = 24;
  localparam logic [4:0] CSI_FRAME_LAST = 5'h17;
  // ============================================================
  // link clock divider: sclk half period in link-clock cycles
  localparam logic [3:0] CSI_HALF_DIV = 4'h2;
  localparam logic [3:0] CSI_CS_GAP = 4'h4;
  // ============================================================
  // sequencer states
  typedef enum logic [4:0] {
    CSI_IDLE = 5'b00001,
    CSI_LOAD = 5'b00010,
    CSI_WAIT = 5'b00100,
    CSI_NEXT = 5'b01000,
    CSI_DONE = 5'b10000
  } csi_state_t;
endpackage
`default_nettype wire

/* include/csi_link_if.sv */
// word handshake carrier between the sequencer and its serial engine
// assumes req/ack toggle crossing; frame word stable while req differs from ack
`default_nettype none
interface csi_link_if;
  logic [23:0] frame;
  logic req_tgl;
  logic ack_tgl;
  modport seq (output frame, output req_tgl, input ack_tgl);
  modport eng (input frame, input req_tgl, output ack_tgl);
endinterface
`default_nettype wire

/* verilog/csi_spi_engine.sv */
// serial engine on the link clock: shifts one 24-bit frame per request
// assumes the frame word is held stable until the acknowledge toggles back
`default_nettype none
module csi_spi_engine
  import csi_pkg::*;
(
  input wire logic lclk,
  input wire logic lrst_b,
  csi_link_if.eng lnk,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack;
    logic busy;
    logic [23:0] shreg;
    logic [4:0] bitn;
    logic [3:0] div;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic gap;
  } csi_eng_t;
  csi_eng_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.req_s1 = lnk.req_tgl;
    st_nxt.req_s2 = st_r.req_s1;
    if (!st_r.busy) begin
      if (st_r.req_s2 != st_r.req_seen) begin
        st_nxt.req_seen = st_r.req_s2;
        st_nxt.busy = 1'b1;
        st_nxt.shreg = lnk.frame;
        st_nxt.cs_n = 1'b0;
        st_nxt.mosi = lnk.frame[CSI_FRAME_W-1];
        st_nxt.bitn = 5'h00;
        st_nxt.div = 4'h0;
        st_nxt.gap = 1'b0;
      end
    end else if (st_r.gap) begin
      // keep chip select high for a gap so back-to-back frames separate
      st_nxt.div = st_r.div + 4'h1;
      if (st_r.div == CSI_CS_GAP) begin
        st_nxt.busy = 1'b0;
        st_nxt.ack = st_r.req_seen;
      end
    end else begin
      st_nxt.div = st_r.div + 4'h1;
      if (st_r.div == CSI_HALF_DIV - 4'h1) begin
        st_nxt.div = 4'h0;
        st_nxt.sclk = ~st_r.sclk;
        if (st_r.sclk) begin
          // falling edge: shift, slave samples on rising
          if (st_r.bitn == CSI_FRAME_LAST) begin
            st_nxt.cs_n = 1'b1;
            st_nxt.gap = 1'b1;
          end else begin
            st_nxt.bitn = st_r.bitn + 5'h01;
            st_nxt.shreg = {st_r.shreg[22:0], 1'b0};
            st_nxt.mosi = st_r.shreg[22];
          end
        end
      end
    end
  end

  always_ff @(posedge lclk) begin
    if (!lrst_b) begin
      st_r <= '0;
      st_r.cs_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sclk = st_r.sclk;
  assign cs_n = st_r.cs_n;
  assign mosi = st_r.mosi;
  assign lnk.ack_tgl = st_r.ack;

  // ============================================================
  // checks
  property p_cs_idle;
    @(posedge lclk) disable iff (!lrst_b)
    !st_r.busy |-> st_r.cs_n && !st_r.sclk;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("chip select active while idle");
  property p_ack_after;
    @(posedge lclk) disable iff (!lrst_b)
    $changed(st_r.ack) |-> $past(st_r.cs_n);
  endproperty
  a_ack_after: assert property (p_ack_after) else $error("acknowledge before frame ended");
endmodule
`default_nettype wire

/* testbench/csi_conv_model.sv */
// behavioural converter on the serial control port, slave side
// assumes frames come MSB first, sampled on rising sclk while cs_n is low
`default_nettype none
module csi_conv_model
  import csi_pkg::*;
(
  input wire logic lrst_b,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic [23:0] got [0:7],
  output int n_got
);
  timeunit 1ns;
  timeprecision 100ps;
  // ============================================================
  // strap and shift capture
  logic converter_serial_out_pin;
  logic [23:0] sh;
  int nb = 0;
  // pulled low at start-up so the converter masters the audio clocks
  assign converter_serial_out_pin = 1'b0;
  always @(negedge cs_n) begin
    sh = '0;
    nb = 0;
  end
  always @(posedge sclk) begin
    if (!cs_n) begin
      sh = {sh[22:0], mosi};
      nb++;
    end
  end
  // a short frame or a foreign chip address is not recognised: kept as unknown
  always @(posedge cs_n or negedge lrst_b) begin
    if (!lrst_b) begin
      n_got = 0;
    end else if (nb > 0 && n_got < 8) begin
      got[n_got] = (nb == 24 && sh[23:18] == CSI_CHIP_ADDR) ? sh : 24'hXXXXXX;
      n_got++;
      nb = 0;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_csi_codec_init.sv */
// self-checking bench for the converter start-up sequencer
// assumes csi_conv_model listens on the serial pins; both resets asserted together, rst_b released 38 cycles before lrst_b
`default_nettype none
module tb_csi_codec_init
  import csi_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  // ============================================================
  // clocks, pins, counters
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic rst_b = 1'b0;
  logic lrst_b = 1'b0;
  logic converter_enable_n = 1'b1;
  logic mute_sel = 1'b0;
  logic spi_sclk, spi_cs_n, spi_mosi, init_busy, init_done;
  logic [23:0] got [0:7];
  int n_got;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  always #40 lclk = ~lclk;
  csi_codec_init i_csi_codec_init (.mclk(mclk), .rst_b(rst_b), .lclk(lclk), .lrst_b(lrst_b),
    .converter_enable_n(converter_enable_n), .mute_sel(mute_sel), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .init_busy(init_busy), .init_done(init_done));
  csi_conv_model i_csi_conv_model (.lrst_b(lrst_b), .sclk(spi_sclk), .cs_n(spi_cs_n),
    .mosi(spi_mosi), .got(got), .n_got(n_got));
  // ============================================================
  // shared tasks
  task automatic conclude();
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      $display("[FAIL] %0t timeout", $time);
      conclude();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk_frame(input logic [23:0] g, input logic [23:0] e, input string what);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string what);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, g, e);
    end
  endtask
  // link reset outlasts three link-clock edges; enable dropped so every run starts gated
  task automatic do_reset();
    converter_enable_n = 1'b1;
    rst_b = 1'b0;
    lrst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(38);
    lrst_b = 1'b1;
    tick(2);
    chk_bit(init_busy, 1'b0, "busy after reset");
    chk_bit(init_done, 1'b0, "done after reset");
    chk_bit(spi_cs_n, 1'b1, "cs after reset");
    chk_bit(spi_sclk, 1'b0, "sclk after reset");
    chk_bit(spi_mosi, 1'b0, "mosi after reset");
  endtask
  // ============================================================
  // scenarios
  task automatic t_gated();
    tick(400);
    chk_bit(spi_cs_n, 1'b1, "cs while disabled");
    chk_bit(spi_sclk, 1'b0, "sclk idle");
    chk_bit(init_busy, 1'b0, "busy while disabled");
    chk_bit(init_done, 1'b0, "done while disabled");
    chk_frame(24'(n_got), 24'h000000, "frames while disabled");
  endtask
  task automatic t_program(input logic mute, input logic drop_enable);
    logic [2:0] ptr [0:5];
    logic [7:0] val [0:5];
    int i;
    ptr = '{CSI_BYTE_ADC, CSI_BYTE_DAC, CSI_BYTE_ATT_L, CSI_BYTE_ATT_R, CSI_BYTE_DSP, CSI_BYTE_MCLK};
    val = '{8'h00, mute ? 8'h60 : 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00};
    mute_sel = mute;
    converter_enable_n = 1'b0;
    for (i = 0; i < 20 && init_busy !== 1'b1; i++)
      tick(1);
    chk_bit(init_busy, 1'b1, "busy after start");
    // a late disable must not stop a sequence already under way
    if (drop_enable)
      converter_enable_n = 1'b1;
    for (i = 0; i < 15000 && init_done !== 1'b1; i++)
      tick(1);
    chk_bit(init_done, 1'b1, "done");
    chk_bit(init_busy, 1'b0, "busy after done");
    for (i = 0; i < 6; i++)
      chk_frame(got[i], {CSI_CHIP_ADDR, 1'b0, 6'h00, ptr[i], val[i]}, "frame");
    tick(3000);
    chk_frame(24'(n_got), 24'h000006, "frame count");
    chk_bit(spi_cs_n, 1'b1, "cs after done");
    chk_bit(init_done, 1'b1, "done held");
  endtask
  // ============================================================
  // main sequence
  initial begin
    do_reset();
    t_gated();
    t_program(1'b0, 1'b0);
    do_reset();
    t_program(1'b1, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
